// ---- core/mcp_consts.svh ----
// constants for the memory controller pin block
`ifndef MCP_CONSTS_SVH
`define MCP_CONSTS_SVH

// machine assignment codes per chip-select region
`define MCP_MACH_GENERAL_CHIPSELECT_MACHINE    2'h0
`define MCP_MACH_UPM     2'h1
`define MCP_MACH_SDRAM   2'h2
`define MCP_MACH_NONE    2'h3

// largest transfer size code: 2**5 = 32 bytes, four beats on a 64-bit port
`define MCP_SIZE_MAX     3'h5

// buffer control selection codes
`define MCP_BCTL_DIR_EN  2'h0
`define MCP_BCTL_WR_RD   2'h1
`define MCP_BCTL_EN_DIR  2'h2
`define MCP_BCTL_OFF     2'h3

// timing counts in clk cycles
`define MCP_MON_LIMIT    10'h100
`define MCP_SD_RCD       3'h2
`define MCP_SD_CL        3'h2

// address bit carried on the a10 line in the row phase
`define MCP_A10_ROW_BIT  20

// last step of the programmable machine's store
`define MCP_UPM_LAST     4'hf

`endif

// ---- core/mcp_pkg.sv ----
// types shared by the memory controller pin block
package mcp_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_GP_ADDR,
      ST_GP_STRB,
      ST_UP_RUN,
      ST_SD_ACT,
      ST_SD_CMD,
      ST_SD_DATA
   } mcp_state_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [2:0]  bank;
      logic [2:0]  size;
      logic [31:0] addr;
      logic [63:0] wdata;
   } mcp_req_t;

   typedef struct packed {
      logic [7:0][1:0] bank_machine;
      logic [7:0][1:0] bank_port;
      logic [1:0]      buffer_ctrl_select_field;
      logic            ext_master;
      logic            parity_sep;
      logic            sdram_auto_pre;
   } mcp_cfg_t;

   typedef struct packed {
      logic [5:0] gpl;
      logic       cs_en;
      logic       bs_en;
      logic       last;
   } mcp_upm_word_t;

   typedef struct packed {
      logic          we;
      logic [3:0]    addr;
      mcp_upm_word_t word;
   } mcp_upm_load_t;

   typedef struct packed {
      logic beat_data_valid;
      logic transfer_ack;
      logic transfer_error_ack;
   } mcp_resp_t;

   typedef struct packed {
      logic [7:0] cs_n;
      logic [7:0] lane_write_enable_n;
      logic [7:0] sdram_lane_mask;
      logic [7:0] prog_machine_byte_select_n;
      logic [5:0] prog_general_line;
      logic       memory_output_enable_n;
      logic       sdram_row_strobe_n;
      logic       sdram_column_strobe_n;
      logic       sdram_write_strobe_n;
      logic       sdram_addr_bit_ten;
      logic       sdram_addr_mux_ctrl;
      logic       address_latch;
      logic       buffer_ctrl_zero;
      logic       buffer_ctrl_one;
      logic       parity_chip_select_n;
      logic [1:0] burst_address_bits;
      logic [7:0] lane_parity;
   } mcp_pins_t;

endpackage : mcp_pkg

// ---- core/mcp_mem_ctrl.sv ----
// memory controller pin engines: chip-select, programmable and sdram
//
// Summary of operation
// - eight active-low chip selects, one per memory region.
// - two buffer controls whose behaviour follows a selection field.
// - burst address bits 27-28 follow the current beat address.
// - address latch strobe pulses before a transfer in external-master mode.
// - chip-select machine drives eight per-lane write enables on writes.
// - sdram machine drives eight per-lane data masks.
// - programmable machine byte selects from address, size and port size.
// - a10 carries row address on activate, auto-precharge on column command.
// - six general lines driven purely by the programmable machine's store.
// - sdram write, row and column strobes drive sdram command pins.
// - chip-select machine drives output enable during reads.
// - chip-select machine ends each beat on the external acknowledge.
// - programmable machine pauses while the wait input is high.
// - parity chip select follows the byte strobes when enabled.
// - sdram address mux control switches in external-master mode.
// - data-valid on every beat, acknowledge only with the last.
// - double doubleword to a 32-bit port gives four beats.
// - bus monitor raises transfer error on a hung transfer.
// - single beat ends on one acknowledge, a burst on the acknowledge of its last beat.
// - each lane parity bit gives odd parity over its byte.
`include "mcp_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module mcp_mem_ctrl
   import mcp_pkg::*;
(
   input  wire logic    clk,
   input  wire logic    nrst,
   input  var mcp_req_t req,
   output logic         req_ready,
   input  var mcp_cfg_t system_unit_module_config,
   input  var mcp_upm_load_t upm_load,
   input  wire logic    chipsel_machine_ack_in_n,
   input  wire logic    prog_machine_wait_in,
   output mcp_pins_t    mem_pins,
   output mcp_resp_t    bus_resp
);

   localparam mcp_pins_t PINS_IDLE = '{
      cs_n:                       8'hff,
      lane_write_enable_n:        8'hff,
      sdram_lane_mask:            8'hff,
      prog_machine_byte_select_n: 8'hff,
      prog_general_line:          6'h00,
      memory_output_enable_n:     1'b1,
      sdram_row_strobe_n:         1'b1,
      sdram_column_strobe_n:      1'b1,
      sdram_write_strobe_n:       1'b1,
      sdram_addr_bit_ten:         1'b0,
      sdram_addr_mux_ctrl:        1'b0,
      address_latch:              1'b0,
      buffer_ctrl_zero:           1'b0,
      buffer_ctrl_one:            1'b0,
      parity_chip_select_n:       1'b1,
      burst_address_bits:         2'h0,
      lane_parity:                8'hff
   };

   mcp_cfg_t      cfg;
   mcp_state_t    state_q;
   mcp_state_t    state_d;
   logic [31:0]   addr_q;
   logic [2:0]    bank_q;
   logic          wr_q;
   logic [1:0]    plog_q;
   logic [1:0]    blog_q;
   logic [5:0]    beats_q;
   logic [2:0]    dly_q;
   logic [2:0]    dly_d;
   logic [9:0]    mon_q;
   logic [3:0]    pc_q;
   logic          ack_s1_q;
   logic          ack_s2_q;
   logic          wt_s1_q;
   logic          wt_s2_q;
   logic [7:0]    par_q;
   mcp_pins_t     pins_q;
   mcp_pins_t     pins_d;
   mcp_resp_t     resp_q;
   mcp_upm_word_t upm_mem [16];

   assign cfg = system_unit_module_config;

   // request decode
   wire [1:0] req_mach = cfg.bank_machine[req.bank];
   wire [1:0] req_plog = cfg.bank_port[req.bank];
   wire       req_bad  = (req_mach == `MCP_MACH_NONE) ||
                         (req.size > `MCP_SIZE_MAX);
   wire       start    = (state_q == ST_IDLE) && req.valid;
   wire       start_ok = start && !req_bad;
   wire [1:0] req_blog = (req.size > {1'b0, req_plog}) ?
                         req_plog : req.size[1:0];
   // beats = transfer bytes / bytes per beat
   wire [2:0] beat_shift = req.size - {1'b0, req_blog};
   wire [5:0] req_beats  = 6'h01 << beat_shift;

   assign req_ready = (state_q == ST_IDLE);

   // current step of the programmable machine
   mcp_upm_word_t upm_word;
   assign upm_word = upm_mem[pc_q];

   // beat completion per machine
   wire gp_done = (state_q == ST_GP_STRB) && !ack_s2_q;
   wire up_end  = upm_word.last || (pc_q == `MCP_UPM_LAST);
   wire up_done = (state_q == ST_UP_RUN) && !wt_s2_q && up_end;
   wire sd_done = (state_q == ST_SD_DATA) && (dly_q == 3'h0);
   wire beat_done = gp_done || up_done || sd_done;
   wire last_beat = (beats_q == 6'h01);
   wire timeout   = (mon_q == `MCP_MON_LIMIT);
   wire sd_first  = (state_q == ST_SD_ACT) && (dly_q == `MCP_SD_RCD);

   // lane placement: a narrow port sits on the low lanes
   wire [2:0] port_mask = 3'((4'h1 << plog_q) - 4'h1);
   wire [2:0] lane_off  = addr_q[2:0] & port_mask;
   wire [3:0] beat_bytes = 4'h1 << blog_q;
   wire [3:0] lane_end  = {1'b0, lane_off} + beat_bytes;
   wire [7:0] lane_on;
   wire [7:0] wr_par;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_lane
         assign lane_on[gi] = ({1'b0, 3'(gi)} >= {1'b0, lane_off}) &&
                              ({1'b0, 3'(gi)} < lane_end);
         assign wr_par[gi]  = ~^req.wdata[gi*8 +: 8];
      end
   endgenerate

   // next state
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (start_ok) begin
               unique case (req_mach)
                  `MCP_MACH_GENERAL_CHIPSELECT_MACHINE: state_d = ST_GP_ADDR;
                  `MCP_MACH_UPM:  state_d = ST_UP_RUN;
                  default:        state_d = ST_SD_ACT;
               endcase
            end
         end
         ST_GP_ADDR: state_d = ST_GP_STRB;
         ST_GP_STRB: begin
            if (gp_done) begin
               state_d = last_beat ? ST_IDLE : ST_GP_ADDR;
            end
         end
         ST_UP_RUN: begin
            if (up_done && last_beat) begin
               state_d = ST_IDLE;
            end
         end
         ST_SD_ACT: begin
            if (dly_q == 3'h0) begin
               state_d = ST_SD_CMD;
            end
         end
         ST_SD_CMD: state_d = ST_SD_DATA;
         ST_SD_DATA: begin
            if (sd_done && last_beat) begin
               state_d = ST_IDLE;
            end
         end
      endcase
      if (timeout) begin
         state_d = ST_IDLE;
      end
   end

   // delay counter: activate-to-command, then read latency
   always_comb begin
      dly_d = dly_q;
      if (start_ok) begin
         dly_d = `MCP_SD_RCD;
      end else if (state_q == ST_SD_CMD) begin
         dly_d = wr_q ? 3'h0 : `MCP_SD_CL;
      end else if (dly_q != 3'h0) begin
         dly_d = dly_q - 3'h1;
      end
   end

   // pin values for the next cycle
   wire xfer   = (state_q != ST_IDLE);
   wire gp_on  = (state_q == ST_GP_ADDR) || (state_q == ST_GP_STRB);
   wire sd_on  = (state_q == ST_SD_ACT) || (state_q == ST_SD_CMD) ||
                 (state_q == ST_SD_DATA);
   wire sd_col = (state_q == ST_SD_CMD) || (state_q == ST_SD_DATA);
   wire up_on  = (state_q == ST_UP_RUN);
   wire strobe = (state_q == ST_GP_STRB) || (up_on && upm_word.bs_en) ||
                 sd_col;

   always_comb begin
      pins_d = PINS_IDLE;
      if ((gp_on || sd_on) || (up_on && upm_word.cs_en)) begin
         pins_d.cs_n[bank_q] = 1'b0;
      end
      if ((state_q == ST_GP_STRB) && wr_q) begin
         pins_d.lane_write_enable_n = ~lane_on;
      end
      pins_d.memory_output_enable_n =
         !((state_q == ST_GP_STRB) && !wr_q);
      if (up_on) begin
         pins_d.prog_general_line = upm_word.gpl;
         if (upm_word.bs_en) begin
            pins_d.prog_machine_byte_select_n = ~lane_on;
         end
      end
      if (sd_col) begin
         pins_d.sdram_lane_mask = ~lane_on;
      end
      pins_d.sdram_row_strobe_n    = !sd_first;
      pins_d.sdram_column_strobe_n = !(state_q == ST_SD_CMD);
      pins_d.sdram_write_strobe_n  = !((state_q == ST_SD_CMD) && wr_q);
      if (state_q == ST_SD_ACT) begin
         pins_d.sdram_addr_bit_ten = addr_q[`MCP_A10_ROW_BIT];
      end else if (state_q == ST_SD_CMD) begin
         pins_d.sdram_addr_bit_ten = cfg.sdram_auto_pre;
      end
      pins_d.sdram_addr_mux_ctrl = cfg.ext_master && sd_col;
      // one cycle ahead of the first chip select so the latch holds early
      pins_d.address_latch = cfg.ext_master && start_ok;
      pins_d.parity_chip_select_n = !(cfg.parity_sep && strobe);
      pins_d.burst_address_bits = addr_q[4:3];
      pins_d.lane_parity = par_q;
      unique case (cfg.buffer_ctrl_select_field)
         `MCP_BCTL_DIR_EN: begin
            pins_d.buffer_ctrl_zero = !wr_q;
            pins_d.buffer_ctrl_one  = !xfer;
         end
         `MCP_BCTL_WR_RD: begin
            pins_d.buffer_ctrl_zero = xfer && wr_q;
            pins_d.buffer_ctrl_one  = xfer && !wr_q;
         end
         `MCP_BCTL_EN_DIR: begin
            pins_d.buffer_ctrl_zero = xfer;
            pins_d.buffer_ctrl_one  = wr_q;
         end
         `MCP_BCTL_OFF: begin
            pins_d.buffer_ctrl_zero = 1'b0;
            pins_d.buffer_ctrl_one  = 1'b0;
         end
      endcase
   end

   // response: valid every beat, acknowledge only on the last
   mcp_resp_t resp_d;
   assign resp_d.beat_data_valid    = beat_done && !timeout;
   assign resp_d.transfer_ack       = beat_done && !timeout &&
                                      last_beat;
   assign resp_d.transfer_error_ack = timeout ||
                                      (start && req_bad);

   // pin inputs come from outside: two flops before use
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ack_s1_q <= 1'b1;
         ack_s2_q <= 1'b1;
         wt_s1_q  <= 1'b0;
         wt_s2_q  <= 1'b0;
      end else begin
         ack_s1_q <= chipsel_machine_ack_in_n;
         ack_s2_q <= ack_s1_q;
         wt_s1_q  <= prog_machine_wait_in;
         wt_s2_q  <= wt_s1_q;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= ST_IDLE;
         dly_q   <= 3'h0;
         pins_q  <= PINS_IDLE;
         resp_q  <= '0;
      end else begin
         state_q <= state_d;
         dly_q   <= dly_d;
         pins_q  <= pins_d;
         resp_q  <= resp_d;
      end
   end

   // transaction context
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         addr_q <= 32'h0;
         bank_q <= 3'h0;
         wr_q   <= 1'b0;
         plog_q <= 2'h0;
         blog_q <= 2'h0;
         par_q  <= 8'hff;
      end else if (start_ok) begin
         addr_q <= req.addr;
         bank_q <= req.bank;
         wr_q   <= req.write;
         plog_q <= req_plog;
         blog_q <= req_blog;
         par_q  <= wr_par;
      end else if (beat_done) begin
         addr_q <= addr_q + {28'h0, beat_bytes};
      end
   end

   // beat and monitor counters; the monitor restarts on every beat
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         beats_q <= 6'h0;
         mon_q   <= 10'h0;
      end else begin
         if (start_ok) begin
            beats_q <= req_beats;
         end else if (beat_done) begin
            beats_q <= beats_q - 6'h01;
         end
         if (start_ok || beat_done || !xfer || timeout) begin
            mon_q <= 10'h0;
         end else begin
            mon_q <= mon_q + 10'h001;
         end
      end
   end

   // program counter holds while the wait input is high
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pc_q <= 4'h0;
      end else if (start_ok || !up_on) begin
         pc_q <= 4'h0;
      end else if (!wt_s2_q) begin
         pc_q <= up_end ? 4'h0 : pc_q + 4'h1;
      end
   end

   // program store; contents are undefined until loaded
   always_ff @(posedge clk) begin
      if (upm_load.we) begin
         upm_mem[upm_load.addr] <= upm_load.word;
      end
   end

   assign mem_pins = pins_q;
   assign bus_resp = resp_q;

endmodule : mcp_mem_ctrl

`default_nettype wire

// ---- bench/mcp_mem_ctrl_chk.sv ----
// assertion checker for the memory controller pin block
`timescale 1ns/10ps
`default_nettype none

module mcp_mem_ctrl_chk
   import mcp_pkg::*;
(
   input wire logic          clk,
   input wire logic          nrst,
   input var mcp_req_t       req,
   input wire logic          req_ready,
   input var mcp_cfg_t       system_unit_module_config,
   input var mcp_upm_load_t  upm_load,
   input wire logic          chipsel_machine_ack_in_n,
   input wire logic          prog_machine_wait_in,
   input var mcp_pins_t      mem_pins,
   input var mcp_resp_t      bus_resp
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   function automatic logic [7:0] odd_par(input logic [63:0] w);
      for (int i = 0; i < 8; i++) odd_par[i] = ~^w[8*i +: 8];
   endfunction : odd_par

   sequence s_accept;
      req.valid && req_ready;
   endsequence
   sequence s_end;
      bus_resp.transfer_ack || bus_resp.transfer_error_ack;
   endsequence
   // only a request that is taken captures new parity; refused ones do not
   sequence s_take;
      s_accept ##0 (req.size <= 3'h5 &&
         system_unit_module_config.bank_machine[req.bank] != 2'h3);
   endsequence
   property p_par;
      logic [63:0] w;
      (s_take, w = req.wdata) |-> ##2 mem_pins.lane_parity == odd_par(w);
   endproperty

   AST_ACK_VALID: assert property (
      bus_resp.transfer_ack |-> bus_resp.beat_data_valid)
      else $error("acknowledge without data valid");
   AST_ONE_SELECT: assert property ($onehot0(~mem_pins.cs_n))
      else $error("more than one chip select low");
   AST_WE_OE: assert property (
      !(~&mem_pins.lane_write_enable_n && !mem_pins.memory_output_enable_n))
      else $error("write enable and output enable together");
   AST_RAS_CAS: assert property (
      !mem_pins.sdram_row_strobe_n |-> mem_pins.sdram_column_strobe_n)
      else $error("row and column strobe together");
   AST_LATCH: assert property (mem_pins.address_latch |->
      system_unit_module_config.ext_master ##1 !mem_pins.address_latch)
      else $error("address latch pulse wrong");
   AST_WAIT: assert property (prog_machine_wait_in [*6] |->
      $stable(mem_pins.prog_general_line) && !bus_resp.beat_data_valid)
      else $error("programmable machine ran while held");
   AST_DONE: assert property (s_accept |-> ##[1:400] s_end)
      else $error("transfer never ended");
   AST_READY: assert property (s_end |-> req_ready)
      else $error("not idle on final acknowledge");
   AST_ERR_SIZE: assert property (
      s_accept ##0 (req.size > 3'h5) |=> bus_resp.transfer_error_ack)
      else $error("oversize request not refused");
   AST_ERR_ONLY: assert property (bus_resp.transfer_error_ack |->
      !bus_resp.transfer_ack && !bus_resp.beat_data_valid)
      else $error("error together with data");
   AST_PARITY: assert property (p_par)
      else $error("lane parity not odd");
endmodule : mcp_mem_ctrl_chk

bind mcp_mem_ctrl mcp_mem_ctrl_chk u_chk (.clk(clk), .nrst(nrst),
   .req(req), .req_ready(req_ready),
   .system_unit_module_config(system_unit_module_config),
   .upm_load(upm_load), .chipsel_machine_ack_in_n(chipsel_machine_ack_in_n),
   .prog_machine_wait_in(prog_machine_wait_in), .mem_pins(mem_pins),
   .bus_resp(bus_resp));
`default_nettype wire

// ---- bench/mcp_mem_model.sv ----
// memory device model: acknowledges and holds off the controller
`timescale 1ns/10ps
`default_nettype none

module mcp_mem_model
   import mcp_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       nrst,
   input  var mcp_pins_t   pins,
   input  wire logic [3:0] delay,
   output logic            ack_n,
   output logic            wait_hi
);
   logic [3:0] cnt_q;
   logic       sel;

   assign sel = ~&pins.cs_n;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) cnt_q <= 4'h0;
      else if (!sel) cnt_q <= 4'h0;
      else if (cnt_q != 4'hf) cnt_q <= cnt_q + 4'h1;
   end
   // pull-up keeps the line high; delay f stands for a dead device
   assign ack_n = !(sel && cnt_q >= delay && delay != 4'hf);
   // slow device holds wait only while its byte strobes are active
   assign wait_hi = ~&pins.prog_machine_byte_select_n && cnt_q < delay;
endmodule : mcp_mem_model
`default_nettype wire

// ---- bench/mcp_mem_ctrl_test.sv ----
// self-checking bench for the memory controller pin block
`timescale 1ns/10ps
`default_nettype none
`include "mcp_consts.svh"

module mcp_mem_ctrl_test
   import mcp_pkg::*;
;
   logic          clk, nrst, req_ready, ack_n, wait_hi;
   mcp_req_t      req;
   mcp_cfg_t      cfg;
   mcp_upm_load_t programmable_machine;
   mcp_pins_t     pins;
   mcp_resp_t     resp;
   logic [3:0]    dly;
   logic [5:0]    gpl_or;
   int            err_count, tests_run, seed;

   mcp_mem_ctrl DUT (.clk(clk), .nrst(nrst), .req(req),
      .req_ready(req_ready), .system_unit_module_config(cfg),
      .upm_load(programmable_machine), .chipsel_machine_ack_in_n(ack_n),
      .prog_machine_wait_in(wait_hi), .mem_pins(pins), .bus_resp(resp));
   mcp_mem_model u_dev (.clk(clk), .nrst(nrst), .pins(pins), .delay(dly),
      .ack_n(ack_n), .wait_hi(wait_hi));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic check(input string name, input logic [7:0] seen,
                        input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic conclude;
      if (err_count == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : conclude

   function automatic int nbeats(input logic [2:0] sz, input logic [1:0] pt);
      return (sz > {1'b0, pt}) ? (1 << (sz - pt)) : 1;
   endfunction : nbeats

   function automatic logic [7:0] lanes(input logic [2:0] sz,
                                        input logic [1:0] pt,
                                        input logic [2:0] a);
      int bb;
      bb = 1 << ((sz < pt) ? sz : pt);
      return 8'(((1 << bb) - 1) << ((sz < pt) ? (a & ((1 << pt) - 1)) : 0));
   endfunction : lanes

   // buffer control pair {zero, one} while a transfer is busy
   function automatic logic [1:0] bctl_exp(input logic [1:0] sel,
                                           input logic       wr);
      case (sel)
         `MCP_BCTL_DIR_EN: return {!wr, 1'b0};
         `MCP_BCTL_WR_RD:  return {wr, !wr};
         `MCP_BCTL_EN_DIR: return {1'b1, wr};
         default:          return 2'h0;
      endcase
   endfunction : bctl_exp

   // one request, then watch pins and responses until it ends
   task automatic xfer(input logic [2:0] bk, input logic [2:0] sz,
                       input logic wr, input logic hang);
      logic [7:0] cs_s, we_s;
      logic [7:0] bs_s, dqm_s;
      logic [5:0] gp_s;
      logic       oe_s, ras_s, bad, fail;
      logic       mux_s, pcs_s;
      logic [1:0] mc, pt;
      int         vld, ack, err, n, ale;
      {cs_s, we_s, gp_s, oe_s, ras_s, vld, ack, err} = '0;
      {bs_s, dqm_s, mux_s, pcs_s, ale} = '0;
      mc = cfg.bank_machine[bk];
      pt = cfg.bank_port[bk];
      bad = (mc == 2'h3) || (sz > 3'h5);
      fail = bad || hang;
      req.bank = bk;
      req.size = sz;
      req.write = wr;
      req.addr = $random(seed) & ~((32'h1 << sz) - 32'h1);
      req.wdata = {$random(seed), $random(seed)};
      req.valid = 1'b1;
      check("ready", 8'(req_ready), 8'h1);
      @(negedge clk);
      req.valid = 1'b0;
      for (n = 0; n < 400 && ack + err == 0; n++) begin
         cs_s |= ~pins.cs_n;
         we_s |= ~pins.lane_write_enable_n;
         gp_s |= pins.prog_general_line;
         oe_s |= ~pins.memory_output_enable_n;
         ras_s |= ~pins.sdram_row_strobe_n;
         vld += (resp.beat_data_valid === 1'b1);
         ack += (resp.transfer_ack === 1'b1);
         err += (resp.transfer_error_ack === 1'b1);
         bs_s |= ~pins.prog_machine_byte_select_n;
         dqm_s |= ~pins.sdram_lane_mask;
         mux_s |= pins.sdram_addr_mux_ctrl;
         pcs_s |= ~pins.parity_chip_select_n;
         ale += (pins.address_latch === 1'b1);
         // second cycle after accept: context loaded, no beat done yet
         if (n == 1) begin
            check("burst", 8'(pins.burst_address_bits),
                  8'(req.addr[4:3]));
            check("bctl", 8'({pins.buffer_ctrl_zero,
                  pins.buffer_ctrl_one}),
                  8'(bctl_exp(cfg.buffer_ctrl_select_field, wr)));
         end
         if (!pins.sdram_row_strobe_n) begin
            check("a10 row", 8'(pins.sdram_addr_bit_ten),
                  8'(req.addr[`MCP_A10_ROW_BIT]));
         end
         if (!pins.sdram_column_strobe_n) begin
            check("a10 col", 8'(pins.sdram_addr_bit_ten),
                  8'(cfg.sdram_auto_pre));
         end
         @(negedge clk);
      end
      check("error", 8'(err), 8'(fail));
      check("valid", 8'(vld), fail ? 8'h0 : 8'(nbeats(sz, pt)));
      check("ack", 8'(ack), 8'(!fail));
      check("select", cs_s, bad ? 8'h0 : 8'h1 << bk);
      check("lanes", we_s, (!bad && mc == 2'h0 && wr) ?
            lanes(sz, pt, req.addr[2:0]) : 8'h0);
      check("oe", 8'(oe_s), 8'(!bad && mc == 2'h0 && !wr));
      check("ras", 8'(ras_s), 8'(!bad && mc == 2'h2));
      check("gpl", 8'(gp_s), (!bad && mc == 2'h1) ? 8'(gpl_or) : 8'h0);
      check("bytesel", bs_s, (!bad && mc == 2'h1) ?
            lanes(sz, pt, req.addr[2:0]) : 8'h0);
      check("mask", dqm_s, (!bad && mc == 2'h2) ?
            lanes(sz, pt, req.addr[2:0]) : 8'h0);
      check("mux", 8'(mux_s),
            8'(!bad && mc == 2'h2 && cfg.ext_master));
      check("par sel", 8'(pcs_s), 8'(!bad));
      check("latch", 8'(ale), 8'(!bad && cfg.ext_master));
   endtask : xfer

   initial begin
      seed = 32'h15d8;
      err_count = 0;
      tests_run = 0;
      gpl_or = 6'h00;
      nrst = 1'b0;
      req = '0;
      programmable_machine = '0;
      dly = 4'h1;
      cfg = '0;
      cfg.bank_machine = 16'h0390;
      cfg.bank_port = 16'h84fb;
      cfg.parity_sep = 1'b1;
      cfg.sdram_auto_pre = 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      check("reset cs", pins.cs_n, 8'hff);
      check("reset resp", 8'(resp), 8'h0);
      nrst = 1'b1;
      for (int i = 0; i < 16; i++) begin
         programmable_machine.we = 1'b1;
         programmable_machine.addr = 4'(i);
         programmable_machine.word = {6'($random(seed)), 1'b1, 1'b1, i == 3};
         if (i < 4) gpl_or |= programmable_machine.word.gpl;
         @(negedge clk);
      end
      programmable_machine.we = 1'b0;
      xfer(3'h1, 3'h4, 1'b1, 1'b0);
      dly = 4'hf;
      xfer(3'h0, 3'h3, 1'b0, 1'b1);
      xfer(3'h4, 3'h2, 1'b0, 1'b0);
      xfer(3'h2, 3'h6, 1'b1, 1'b0);
      repeat (60) begin
         dly = 4'({$random(seed)} % 12);
         cfg.buffer_ctrl_select_field = 2'($random(seed));
         cfg.ext_master = 1'($random(seed));
         xfer(3'($random(seed)), 3'({$random(seed)} % 7),
              1'($random(seed)), 1'b0);
      end
      conclude();
   end

   initial begin
      repeat (40000) @(posedge clk);
      err_count++;
      conclude();
   end
endmodule : mcp_mem_ctrl_test
`default_nettype wire
